// ---- dllcc_top.sv ----
// Loop clock control: register slave, clock settings and lock status
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "dllcc_cfg.svh"
module dllcc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Loop settings and control
    output dllcc_pkg::dllcc_clk_cfg_t clk_cfg,
    output logic loop_reset_trigger,
    output logic loop_locked,
    // Interrupt
    output logic irq
);
    // ============================================================
    // Decode helpers

    // Post divide code gives ratio 1 to 6 or 8
    function automatic logic post_ok(input logic [3:0] code);
        post_ok = (code >= 4'h1 && code <= 4'h6) || code == 4'h8;
    endfunction

    // Output divider ratio
    function automatic logic [2:0] out_ratio(input logic [1:0] code);
        case (code)
            2'b10: out_ratio = 3'h2;
            2'b11: out_ratio = 3'h4;
            default: out_ratio = 3'h1;
        endcase
    endfunction

    // ============================================================
    // Storage
    // Reset image of the first control register, spare bit 5 dropped
    localparam logic [7:0] SEL_DIV_RST = `DLLCC_RST_SEL_DIV;
    dllcc_pkg::dllcc_ctl0_t ctl0_q;
    dllcc_pkg::dllcc_ctl1_t ctl1_q;
    dllcc_pkg::dllcc_clk_cfg_t cfg_q;
    logic rst_bit_q;
    logic trig_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [2:0] irq_ev;
    logic [7:0] idx;
    logic req;
    logic wr_go;
    logic rd_take;
    logic wr_c0;
    logic wr_c1;
    logic wr_rst;
    logic wr_stat;
    logic wr_mask;
    logic cfg_change;
    logic trig_d;
    logic locked;
    logic lock_gain;
    logic lock_loss;

    // ============================================================
    // Bus handshake: one wait cycle, then the answer
    assign idx = avs_address[9:2];
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_go = avs_write & ack_q & avs_byteenable[0];
    assign rd_take = avs_read & ~ack_q;
    assign avs_readdata = rdata_q;

    // Acknowledge toggles once per request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Write strobes per register
    assign wr_c0 = wr_go && idx == `DLLCC_IDX_SEL_DIV;
    assign wr_c1 = wr_go && idx == `DLLCC_IDX_MUL_LOCK;
    assign wr_rst = wr_go && idx == `DLLCC_IDX_RST_CTL;
    assign wr_stat = wr_go && idx == `DLLCC_IDX_IRQ_STAT;
    assign wr_mask = wr_go && idx == `DLLCC_IDX_IRQ_MASK;

    // ============================================================
    // Control registers

    // Clock select, reference gate, post divide
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl0_q <= {SEL_DIV_RST[7:6], SEL_DIV_RST[4:0]};
        end else if (wr_c0) begin
            ctl0_q.adc_sel <= avs_writedata[`DLLCC_B_ADC_SEL];
            ctl0_q.dac_sel <= avs_writedata[`DLLCC_B_DAC_SEL];
            ctl0_q.ref_en <= avs_writedata[`DLLCC_B_REF_EN];
            ctl0_q.post_div <= avs_writedata[3:0];
        end
    end

    // Output divider and multiplication; lock bit is not stored
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl1_q <= `DLLCC_RST_MUL;
        end else if (wr_c1) begin
            ctl1_q <= avs_writedata[6:0];
        end
    end

    // Loop reset bit; only bit 3 is kept, the rest read zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rst_bit_q <= 1'b0;
        end else if (wr_rst) begin
            rst_bit_q <= avs_writedata[`DLLCC_B_RST];
        end
    end

    // Reset pulse only on a zero to one change
    assign trig_d = wr_rst & avs_writedata[`DLLCC_B_RST] & ~rst_bit_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
        end
    end
    assign loop_reset_trigger = trig_q;

    // Any altered setting invalidates the current lock
    assign cfg_change = (wr_c0 && {avs_writedata[7:6], avs_writedata[4:0]} != ctl0_q)
        || (wr_c1 && avs_writedata[6:0] != ctl1_q);

    // ============================================================
    // Decoded settings to the analog loop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else begin
            cfg_q.adc_sel <= ctl0_q.adc_sel;
            cfg_q.dac_sel <= ctl0_q.dac_sel;
            cfg_q.ref_en <= ctl0_q.ref_en;
            cfg_q.post_ratio <= ctl0_q.post_div;
            cfg_q.cfg_valid <= post_ok(ctl0_q.post_div);
            cfg_q.out_ratio <= out_ratio(ctl1_q.out_div);
            cfg_q.mult_factor <= {1'b0, ctl1_q.mult} + 6'h01;
        end
    end
    assign clk_cfg = cfg_q;

    // ============================================================
    // Lock sequencer
    dllcc_lock_seq u_dllcc_lock_seq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .reset_pulse(trig_q),
        .cfg_change(cfg_change),
        .ref_en(ctl0_q.ref_en),
        .cfg_ok(post_ok(ctl0_q.post_div)),
        .locked(locked),
        .lock_gain(lock_gain),
        .lock_loss(lock_loss)
    );
    assign loop_locked = locked;

    // ============================================================
    // Interrupts
    assign irq_ev = {wr_c0 & ~post_ok(avs_writedata[3:0]), lock_loss, lock_gain};

    // Sticky status, write one to clear, a new event wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_stat_q <= `DLLCC_RST_IRQ;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? avs_writedata[2:0] : 3'h0)) | irq_ev;
        end
    end

    // Mask register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_mask_q <= `DLLCC_RST_IRQ;
        end else if (wr_mask) begin
            irq_mask_q <= avs_writedata[2:0];
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // ============================================================
    // Read data, captured in the wait cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0;
        end else if (rd_take) begin
            case (idx)
                `DLLCC_IDX_SEL_DIV: rdata_q <= {24'h0, ctl0_q.adc_sel, ctl0_q.dac_sel,
                    1'b0, ctl0_q.ref_en, ctl0_q.post_div};
                `DLLCC_IDX_MUL_LOCK: rdata_q <= {24'h0, locked, ctl1_q};
                `DLLCC_IDX_RST_CTL: rdata_q <= {28'h0, rst_bit_q, 3'h0};
                `DLLCC_IDX_IRQ_STAT: rdata_q <= {29'h0, irq_stat_q};
                `DLLCC_IDX_IRQ_MASK: rdata_q <= {29'h0, irq_mask_q};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    // ============================================================
    // Assertion helpers

    // Cycles since the last loop reset pulse, saturating
    localparam logic [9:0] LOCK_CYC = 10'(`DLLCC_LOCK_CYC);
    logic [9:0] since_trig_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            since_trig_q <= 10'h3FF;
        end else if (loop_reset_trigger) begin
            since_trig_q <= 10'h000;
        end else if (since_trig_q != 10'h3FF) begin
            since_trig_q <= since_trig_q + 10'h001;
        end
    end

    // ============================================================
    // Assertions
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_adc_clock_sel: assert property (
        wr_c0 |=> ##1 clk_cfg.adc_sel == $past(avs_writedata[7], 2))
        else $error("sampler clock select does not follow write");

    a_dac_clock_sel: assert property (
        wr_c0 |=> ##1 clk_cfg.dac_sel == $past(avs_writedata[6], 2))
        else $error("transmit clock select does not follow write");

    a_ref_gate: assert property (
        (wr_c0 && !avs_writedata[4]) |=> ##1 !clk_cfg.ref_en && !loop_locked)
        else $error("reference not blocked after clear");

    a_post_div_valid: assert property (
        (wr_c0 && avs_writedata[3:0] == 4'h7) |=> ##1 !clk_cfg.cfg_valid && irq_stat_q[2])
        else $error("invalid post divide code accepted");

    a_lock_readback: assert property (
        (avs_read && !avs_waitrequest && idx == `DLLCC_IDX_MUL_LOCK)
        |-> avs_readdata[7] == $past(loop_locked))
        else $error("lock flag readback wrong");

    a_out_div_ratio: assert property (
        (wr_c1 && avs_writedata[6:5] == 2'b11) |=> ##1 clk_cfg.out_ratio == 3'h4)
        else $error("output divider not by four");

    a_mult_factor: assert property (
        (wr_c1 && avs_writedata[4:0] == 5'h1F) |=> ##1 clk_cfg.mult_factor == 6'h20)
        else $error("multiply factor not thirty two");

    a_reset_rise: assert property (
        wr_rst |=> loop_reset_trigger == ($past(avs_writedata[3]) && !$past(rst_bit_q)))
        else $error("loop reset not tied to rising bit");

    a_lock_clear: assert property (
        loop_reset_trigger |=> !loop_locked [*8])
        else $error("lock flag set too soon after reset");

    a_irq_level: assert property (
        $rose(irq) |-> $past(irq_ev) != 3'h0 || $past(wr_mask))
        else $error("interrupt rose without cause");

    a_wait_one_cycle: assert property (
        avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");

    a_read_data_hold: assert property (
        (avs_read && !avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved after the answer");

    a_trig_one_cycle: assert property (
        loop_reset_trigger |=> !loop_reset_trigger)
        else $error("loop reset pulse longer than one cycle");

    a_trig_needs_write: assert property (
        !wr_rst |=> !loop_reset_trigger)
        else $error("loop reset pulse without a write");

    a_out_div_bypass: assert property (
        (wr_c1 && !avs_writedata[6]) |=> ##1 clk_cfg.out_ratio == 3'h1)
        else $error("output divider not bypassed");

    a_out_div_half: assert property (
        (wr_c1 && avs_writedata[6:5] == 2'b10) |=> ##1 clk_cfg.out_ratio == 3'h2)
        else $error("output divider not by two");

    a_mult_follow: assert property (
        wr_c1 |=> ##1 clk_cfg.mult_factor == {1'b0, $past(avs_writedata[4:0], 2)} + 6'h01)
        else $error("multiply factor not code plus one");

    a_post_div_eight: assert property (
        (wr_c0 && avs_writedata[3:0] == 4'h8) |=> ##1 clk_cfg.cfg_valid && clk_cfg.post_ratio == 4'h8)
        else $error("post divide eight not accepted");

    a_ref_blocks_lock: assert property (
        !ctl0_q.ref_en |=> !$rose(loop_locked))
        else $error("lock gained with reference blocked");

    a_bad_post_lock: assert property (
        !post_ok(ctl0_q.post_div) |=> !$rose(loop_locked))
        else $error("lock gained with invalid post divide");

    a_lock_time: assert property (
        $rose(loop_locked) |-> since_trig_q >= LOCK_CYC)
        else $error("lock flag set before the lock time");

    a_status_sticky: assert property (
        (irq_stat_q[0] && !wr_stat) |=> irq_stat_q[0])
        else $error("lock gained status lost without a clear");

    c_lock_gained: cover property (loop_reset_trigger ##[1:600] loop_locked);
    c_lock_lost: cover property (loop_locked ##1 !loop_locked);
    c_bad_code: cover property (wr_c0 && !post_ok(avs_writedata[3:0]));
    c_irq_clear: cover property (irq ##1 !irq);
    c_reset_locked: cover property (loop_locked && loop_reset_trigger);
endmodule // dllcc_top
`default_nettype wire

// ---- dllcc_cfg.svh ----
// Register map, field positions, reset values and timing of the loop clock control
`ifndef DLLCC_CFG_SVH
`define DLLCC_CFG_SVH
// ============================================================
// Register indexes (byte address is four times the index)
`define DLLCC_IDX_SEL_DIV 8'h71
`define DLLCC_IDX_MUL_LOCK 8'h72
`define DLLCC_IDX_RST_CTL 8'h75
`define DLLCC_IDX_IRQ_STAT 8'h80
`define DLLCC_IDX_IRQ_MASK 8'h81
// ============================================================
// Field positions
`define DLLCC_B_ADC_SEL 7
`define DLLCC_B_DAC_SEL 6
`define DLLCC_B_REF_EN 4
`define DLLCC_B_LOCK 7
`define DLLCC_B_RST 3
`define DLLCC_IRQ_GAIN 0
`define DLLCC_IRQ_LOSS 1
`define DLLCC_IRQ_BAD 2
// ============================================================
// Reset values
`define DLLCC_RST_SEL_DIV 8'h01
`define DLLCC_RST_MUL 7'h00
`define DLLCC_RST_IRQ 3'h0
// ============================================================
// Timing
`define DLLCC_CLK_NS 4
`define DLLCC_LOCK_NS 2000
`define DLLCC_LOCK_CYC ((`DLLCC_LOCK_NS + `DLLCC_CLK_NS - 1) / `DLLCC_CLK_NS)
`endif

// ---- dllcc_pkg.sv ----
// Types shared by the loop clock control design
package dllcc_pkg;
    // First control register fields
    typedef struct packed {
        logic adc_sel;
        logic dac_sel;
        logic ref_en;
        logic [3:0] post_div;
    } dllcc_ctl0_t;
    // Second control register writable fields
    typedef struct packed {
        logic [1:0] out_div;
        logic [4:0] mult;
    } dllcc_ctl1_t;
    // Decoded settings driven to the analog loop
    typedef struct packed {
        logic adc_sel;
        logic dac_sel;
        logic ref_en;
        logic [5:0] mult_factor;
        logic [3:0] post_ratio;
        logic [2:0] out_ratio;
        logic cfg_valid;
    } dllcc_clk_cfg_t;
    // Lock sequencer states, Gray along idle, acquire, locked
    typedef enum logic [1:0] {
        DLLCC_IDLE = 2'b00,
        DLLCC_ACQ = 2'b01,
        DLLCC_LOCKED = 2'b11
    } dllcc_lock_st_t;
endpackage

// ---- dllcc_lock_seq.sv ----
// Lock acquisition sequencer of the loop
`timescale 1ns/1ns
`default_nettype none
`include "dllcc_cfg.svh"
module dllcc_lock_seq (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Loop control
    input wire logic reset_pulse,
    input wire logic cfg_change,
    input wire logic ref_en,
    input wire logic cfg_ok,
    // Lock status
    output logic locked,
    output logic lock_gain,
    output logic lock_loss
);
    localparam logic [9:0] LOCK_LAST = 10'(`DLLCC_LOCK_CYC - 1);
    dllcc_pkg::dllcc_lock_st_t st_q;
    logic [9:0] cnt_q;
    logic lose;

    // Lock drops on a new reset, a setting change or a gated reference
    assign lose = reset_pulse | cfg_change | ~ref_en;

    // ============================================================
    // State machine
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= dllcc_pkg::DLLCC_IDLE;
        end else begin
            case (st_q)
                dllcc_pkg::DLLCC_IDLE: begin
                    if (reset_pulse) begin
                        st_q <= dllcc_pkg::DLLCC_ACQ;
                    end
                end
                dllcc_pkg::DLLCC_ACQ: begin
                    if (reset_pulse) begin
                        st_q <= dllcc_pkg::DLLCC_ACQ;
                    end else if (cfg_change) begin
                        st_q <= dllcc_pkg::DLLCC_IDLE;
                    end else if (cnt_q == LOCK_LAST && ref_en && cfg_ok) begin
                        st_q <= dllcc_pkg::DLLCC_LOCKED;
                    end
                end
                dllcc_pkg::DLLCC_LOCKED: begin
                    if (reset_pulse) begin
                        st_q <= dllcc_pkg::DLLCC_ACQ;
                    end else if (lose) begin
                        st_q <= dllcc_pkg::DLLCC_IDLE;
                    end
                end
                default: begin
                    st_q <= dllcc_pkg::DLLCC_IDLE;
                end
            endcase
        end
    end

    // Acquire timer, runs only with reference and valid settings
    always_ff @(posedge ref_clk) begin
        if (!rst_n || reset_pulse || st_q != dllcc_pkg::DLLCC_ACQ) begin
            cnt_q <= 10'h000;
        end else if (ref_en && cfg_ok && cnt_q != LOCK_LAST) begin
            cnt_q <= cnt_q + 10'h001;
        end
    end

    // Lock level and status pulses
    assign locked = (st_q == dllcc_pkg::DLLCC_LOCKED);
    assign lock_gain = (st_q == dllcc_pkg::DLLCC_ACQ) && !reset_pulse && !cfg_change
        && cnt_q == LOCK_LAST && ref_en && cfg_ok;
    assign lock_loss = locked && lose;
endmodule // dllcc_lock_seq
`default_nettype wire

// ---- dllcc_host_model.sv ----
// Host model: Avalon-MM master that software uses to reach the loop registers
`timescale 1ns/1ns
`default_nettype none
module dllcc_host_model (
    // Clock
    input wire logic ref_clk,
    // Avalon-MM master side
    output var logic [9:0] avs_address,
    output var logic avs_read,
    output var logic avs_write,
    output var logic [3:0] avs_byteenable,
    output var logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // ============================================================
    // Bus idle at time zero
    initial begin
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'hF;
        avs_writedata = 32'h00000000;
    end
    // One write, held until waitrequest is seen low
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    // One read, data taken at the answer edge
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Loop reset: spare bits kept zero, then a fresh rising edge
    task automatic loop_reset();
        wr(8'h75, 8'h00);
        wr(8'h75, 8'h08);
    endtask
endmodule // dllcc_host_model
`default_nettype wire

// ---- dll_clock_config_bench.sv ----
// Self-checking bench of the loop clock control
`timescale 1ns/1ns
`default_nettype none
`include "dllcc_cfg.svh"
module dll_clock_config_bench;
    // ============================================================
    // Signals
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, loop_reset_trigger, loop_locked, irq;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    dllcc_pkg::dllcc_clk_cfg_t clk_cfg;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int trig_count = 0;
    // ============================================================
    // Instances
    dllcc_top u_dllcc_top (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .clk_cfg(clk_cfg), .loop_reset_trigger(loop_reset_trigger), .loop_locked(loop_locked), .irq(irq));
    dllcc_host_model u_dllcc_host_model (.ref_clk(ref_clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    // Clock at 250 MHz
    always #2 ref_clk = ~ref_clk;
    // Trigger pulse counter and hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (loop_reset_trigger === 1'b1) trig_count <= trig_count + 1;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    // ============================================================
    // Helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        u_dllcc_host_model.wr(idx, d);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] v;
        u_dllcc_host_model.rd(idx, v);
        chk(what, exp, v);
    endtask
    task automatic settle();
        @(posedge ref_clk);
    endtask
    task automatic wait_lock(output int n);
        n = 0;
        while (loop_locked !== 1'b1 && n < 700) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ============================================================
    // Scenarios
    task automatic t_reset();
        rd_chk(8'h71, 8'h01, "sel_div reset");
        rd_chk(8'h72, 8'h00, "mul_lock reset");
        rd_chk(8'h75, 8'h00, "rst_ctl reset");
        rd_chk(8'h80, 8'h00, "status reset");
        rd_chk(8'h81, 8'h00, "mask reset");
        rd_chk(8'h70, 8'h00, "unmapped read");
        chk("post ratio", 4'h1, clk_cfg.post_ratio);
        chk("mult factor", 6'h01, clk_cfg.mult_factor);
        chk("irq", 1'b0, irq);
        $display("Done: reset");
    endtask
    task automatic t_select();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {i[2], i[1], 1'b0, i[0], 4'h1};
            wr(8'h71, v);
            settle();
            chk("adc sel", i[2], clk_cfg.adc_sel);
            chk("dac sel", i[1], clk_cfg.dac_sel);
            chk("ref en", i[0], clk_cfg.ref_en);
            rd_chk(8'h71, v, "sel_div read");
        end
        wr(8'h71, 8'hE1);
        rd_chk(8'h71, 8'hC1, "spare bit");
        $display("Done: select");
    endtask
    task automatic t_post();
        logic ok;
        for (int c = 0; c < 16; c++) begin
            ok = (c >= 1 && c <= 6) || c == 8;
            wr(8'h71, {4'h0, c[3:0]});
            settle();
            chk("post valid", ok, clk_cfg.cfg_valid);
            if (ok) chk("post ratio", c[3:0], clk_cfg.post_ratio);
        end
        rd_chk(8'h80, 8'h04, "bad code flag");
        wr(8'h80, 8'h04);
        rd_chk(8'h80, 8'h00, "flag cleared");
        $display("Done: post divide");
    endtask
    task automatic t_mult();
        int mt[3] = '{0, 1, 31};
        for (int o = 0; o < 4; o++) begin
            for (int k = 0; k < 3; k++) begin
                wr(8'h72, {1'b0, o[1:0], mt[k][4:0]});
                settle();
                chk("out ratio", o < 2 ? 3'h1 : (o == 2 ? 3'h2 : 3'h4), clk_cfg.out_ratio);
                chk("mult factor", mt[k] + 1, clk_cfg.mult_factor);
            end
        end
        wr(8'h72, 8'hFF);
        rd_chk(8'h72, 8'h7F, "lock read only");
        $display("Done: multiply");
    endtask
    task automatic t_lock();
        int n;
        int t;
        wr(8'h71, 8'h11);
        wr(8'h72, 8'h03);
        wr(8'h81, 8'h01);
        n = trig_count;
        u_dllcc_host_model.loop_reset();
        settle();
        chk("one trigger", n + 1, trig_count);
        chk("lock low", 1'b0, loop_locked);
        wait_lock(t);
        chk("lock gained", 1'b1, loop_locked);
        chk("lock time", 1'b1, t >= `DLLCC_LOCK_CYC - 2 && t <= `DLLCC_LOCK_CYC + 2);
        rd_chk(8'h72, 8'h83, "lock flag");
        chk("irq unmasked", 1'b1, irq);
        wr(8'h75, 8'h08);
        settle();
        chk("no trigger", n + 1, trig_count);
        chk("lock kept", 1'b1, loop_locked);
        wr(8'h81, 8'h00);
        chk("irq masked", 1'b0, irq);
        wr(8'h80, 8'h01);
        rd_chk(8'h80, 8'h00, "gain cleared");
        wr(8'h72, 8'h04);
        settle();
        chk("lock lost", 1'b0, loop_locked);
        rd_chk(8'h80, 8'h02, "loss flag");
        u_dllcc_host_model.loop_reset();
        wait_lock(t);
        chk("relock", 1'b1, loop_locked);
        u_dllcc_host_model.loop_reset();
        settle();
        chk("reset drops lock", 1'b0, loop_locked);
        $display("Done: lock");
    endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_select();
        t_post();
        t_mult();
        t_lock();
        complete_run();
    end
endmodule // dll_clock_config_bench
`default_nettype wire
